// ---- rtl/hles_status.sv ----
// Data link event status and enable registers of one HDLC pair

module hles_status
  import hles_pkg::*;
(
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RESET_N,
  // Host register port
  input  wire hles_pkg::hles_addr_type ADDR,
  input  wire hles_pkg::hles_byte_type WDATA,
  input  wire logic                    WR,
  input  wire logic                    RD,
  output hles_pkg::hles_byte_type      RDATA,
  // Transmit controller events
  input  wire logic                    TX_START,
  input  wire logic                    TX_END,
  // Receive controller events
  input  wire logic                    RX_START,
  input  wire logic                    RX_END,
  input  wire logic                    RX_BUFFER_FULL,
  input  wire logic                    RX_FRAME_CHECK_ERROR_EVENT,
  input  wire logic                    RX_MESSAGE_KIND,
  // Receive data link bit stream
  input  wire logic                    RX_BIT,
  input  wire logic                    RX_BIT_VALID,
  // Interrupt request
  output logic                         IRQ
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic           status_read;
  logic           enable_write;
  logic           end_taken;
  logic           end_hit;
  logic           message_kind_flag;
  logic [2:0]     ones_count;
  logic [2:0]     next_ones_count;
  hles_byte_type  rx_shift;
  hles_byte_type  next_rx_shift;
  logic           abort_seen;
  logic           flag_seen;
  hles_event_type set_vec;
  hles_event_type event_flags;
  hles_byte_type  enable_reg;
  hles_byte_type  status_now;
  hles_byte_type  next_rdata;
  logic           next_irq;
  hles_event_type irq_sources;
  // Latched events, one name per status event field
  logic           tx_start_event;
  logic           rx_start_event;
  logic           tx_end_event;
  logic           rx_end_event;
  logic           frame_check_error_event;
  logic           rx_abort_event;
  logic           rx_flag_event;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  // The status event bits clear on any read strobe at its index
  // read clears events
  assign status_read  = RD & (ADDR == STATUS_INDEX);
  assign enable_write = WR & (ADDR == ENABLE_INDEX);

  // ---------------------------------------------------------------
  // End of reception qualification
  // ---------------------------------------------------------------
  // Only the first of message end or buffer full counts per message,
  // so a full buffer followed by the real end is one event, not two.
  // An end in the same cycle as a new start belongs to the old message.
  always_comb begin
    end_hit = (RX_END | RX_BUFFER_FULL) & ~end_taken;
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      end_taken <= 1'h0;
    end else if (RX_START) begin
      end_taken <= 1'h0;
    end else if (end_hit) begin
      end_taken <= 1'h1;
    end
  end

  // ---------------------------------------------------------------
  // Message kind of the last received message
  // ---------------------------------------------------------------
  // Captured when the message is closed so a new start does not
  // disturb the kind of the message software is still handling.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      message_kind_flag <= KIND_RESET;
    end else if (end_hit) begin
      message_kind_flag <= RX_MESSAGE_KIND ? KIND_MESSAGE_ORIENTED
                                           : KIND_BIT_ORIENTED;
    end
  end

  // ---------------------------------------------------------------
  // Abort detection on the receive bit stream
  // ---------------------------------------------------------------
  // Counter saturates so a long run of ones raises one event only,
  // and only a zero bit rearms it
  always_comb begin
    next_ones_count = ones_count;
    if (RX_BIT_VALID) begin
      if (!RX_BIT) begin
        next_ones_count = ONES_RESET;
      end else if (ones_count != ABORT_ONES) begin
        next_ones_count = ones_count + 3'h1;
      end
    end
  end

  always_comb begin
    abort_seen = RX_BIT_VALID & RX_BIT
               & (ones_count == ABORT_ONES - 3'h1);
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ones_count <= ONES_RESET;
    end else begin
      ones_count <= next_ones_count;
    end
  end

  // ---------------------------------------------------------------
  // Flag octet detection on the receive bit stream
  // ---------------------------------------------------------------
  // Bits arrive first in the low position, as on the HDLC line
  // Flags that share a zero bit each raise their own event
  always_comb begin
    next_rx_shift = rx_shift;
    if (RX_BIT_VALID) begin
      next_rx_shift = {RX_BIT, rx_shift[DATA_W-1:1]};
    end
  end

  // Software pairs this event with receive end to see a whole frame
  always_comb begin
    flag_seen = RX_BIT_VALID & (next_rx_shift == FLAG_OCTET);
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rx_shift <= SHIFT_RESET;
    end else begin
      rx_shift <= next_rx_shift;
    end
  end

  // ---------------------------------------------------------------
  // Event collection
  // ---------------------------------------------------------------
  always_comb begin
    set_vec = EVENTS_RESET;
    set_vec[TX_START_BIT] = TX_START;
    set_vec[RX_START_BIT] = RX_START;
    set_vec[TX_END_BIT]   = TX_END;
    set_vec[RX_END_BIT]   = end_hit;
    set_vec[FCS_BIT]      = RX_FRAME_CHECK_ERROR_EVENT;
    set_vec[ABORT_BIT]    = abort_seen;
    set_vec[FLAG_BIT]     = flag_seen;
  end

  // ---------------------------------------------------------------
  // Sticky event flags
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < EVENT_COUNT; i++) begin : g_event
      hles_sticky_bit u_flag (
        .CLK     (CLK),
        .RESET_N (RESET_N),
        .SET     (set_vec[i]),
        .CLEAR   (status_read),
        .FLAG    (event_flags[i])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Latched events by name
  // ---------------------------------------------------------------
  // Picked by field position so the read map follows the package
  always_comb begin
    tx_start_event          = event_flags[TX_START_BIT];
    rx_start_event          = event_flags[RX_START_BIT];
    tx_end_event            = event_flags[TX_END_BIT];
    rx_end_event            = event_flags[RX_END_BIT];
    frame_check_error_event = event_flags[FCS_BIT];
    rx_abort_event          = event_flags[ABORT_BIT];
    rx_flag_event           = event_flags[FLAG_BIT];
  end

  // ---------------------------------------------------------------
  // Enable register
  // ---------------------------------------------------------------
  // Bit 7 has no event behind it and always reads zero
  // enable bits per event
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      enable_reg <= ENABLE_RESET;
    end else if (enable_write) begin
      enable_reg <= WDATA & ENABLE_WRITE_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Writes to the status index are dropped: the kind bit is
  // hardware owned and event bits clear only by reading.
  always_comb begin
    status_now                = STATUS_RESET;
    status_now[KIND_BIT]      = message_kind_flag;
    status_now[TX_START_BIT]  = tx_start_event;
    status_now[RX_START_BIT]  = rx_start_event;
    status_now[TX_END_BIT]    = tx_end_event;
    status_now[RX_END_BIT]    = rx_end_event;
    status_now[FCS_BIT]       = frame_check_error_event;
    status_now[ABORT_BIT]     = rx_abort_event;
    status_now[FLAG_BIT]      = rx_flag_event;
  end

  always_comb begin
    next_rdata = IDLE_DATA;
    if (RD) begin
      case (ADDR)
        STATUS_INDEX: begin
          next_rdata = status_now;
        end
        ENABLE_INDEX: begin
          next_rdata = enable_reg;
        end
        default: begin
          next_rdata = UNMAPPED_DATA;
        end
      endcase
    end
  end

  // Idle data between reads, so a stale value never looks fresh
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      RDATA <= IDLE_DATA;
    end else begin
      RDATA <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt request
  // ---------------------------------------------------------------
  // Registered, so it trails the flags by one cycle; it drops one
  // cycle after the clearing read unless a new event came in.
  always_comb begin
    irq_sources = event_flags & enable_reg[EVENT_COUNT-1:0];
    next_irq    = |irq_sources;
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      IRQ <= 1'h0;
    end else begin
      IRQ <= next_irq;
    end
  end

endmodule

// ---- rtl/hles_pkg.sv ----
// Constants and types shared by the data link event status bank
package hles_pkg;

  // ---------------------------------------------------------------
  // Register port geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  typedef logic [ADDR_W-1:0] hles_addr_type;
  typedef logic [DATA_W-1:0] hles_byte_type;

  // ---------------------------------------------------------------
  // Register indexes on the host port
  // ---------------------------------------------------------------
  localparam hles_addr_type STATUS_INDEX = 4'h0;
  localparam hles_addr_type ENABLE_INDEX = 4'h1;

  // ---------------------------------------------------------------
  // Field positions inside the status and enable registers
  // ---------------------------------------------------------------
  localparam int KIND_BIT     = 7;
  localparam int TX_START_BIT = 6;
  localparam int RX_START_BIT = 5;
  localparam int TX_END_BIT   = 4;
  localparam int RX_END_BIT   = 3;
  localparam int FCS_BIT      = 2;
  localparam int ABORT_BIT    = 1;
  localparam int FLAG_BIT     = 0;
  localparam int EVENT_COUNT  = 7;

  typedef logic [EVENT_COUNT-1:0] hles_event_type;

  // ---------------------------------------------------------------
  // Values after reset and fixed read values
  // ---------------------------------------------------------------
  localparam hles_byte_type  STATUS_RESET      = 8'h00;
  localparam hles_byte_type  ENABLE_RESET      = 8'h00;
  localparam hles_byte_type  UNMAPPED_DATA     = 8'h00;
  localparam hles_byte_type  IDLE_DATA         = 8'h00;
  localparam hles_byte_type  ENABLE_WRITE_MASK = 8'h7F;
  localparam hles_event_type EVENTS_RESET      = 7'h00;
  localparam logic           KIND_RESET        = 1'h0;

  // ---------------------------------------------------------------
  // Message kind encoding
  // ---------------------------------------------------------------
  localparam logic KIND_BIT_ORIENTED     = 1'h0;
  localparam logic KIND_MESSAGE_ORIENTED = 1'h1;

  // ---------------------------------------------------------------
  // Receive line patterns and counts
  // ---------------------------------------------------------------
  localparam hles_byte_type FLAG_OCTET  = 8'h7E;
  localparam logic [2:0]    ABORT_ONES  = 3'h7;
  localparam logic [2:0]    ONES_RESET  = 3'h0;
  localparam hles_byte_type SHIFT_RESET = 8'h00;

endpackage

// ---- rtl/hles_sticky_bit.sv ----
// One sticky event flag: set by hardware, cleared by a clearing read
module hles_sticky_bit (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RESET_N,
  // Event and clear
  input  wire logic SET,
  input  wire logic CLEAR,
  // Flag
  output logic      FLAG
);

  logic next_flag;

  // ---------------------------------------------------------------
  // Set has priority over clear
  // ---------------------------------------------------------------
  always_comb begin
    next_flag = SET | (FLAG & ~CLEAR);
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      FLAG <= 1'h0;
    end else begin
      FLAG <= next_flag;
    end
  end

endmodule

// ---- testbench/hles_status_properties.sv ----
// Port-level checks for the data link event status bank
module hles_status_properties
  import hles_pkg::*;
(
  // Clock and reset
  input wire logic                    CLK,
  input wire logic                    RESET_N,
  // Host register port
  input wire hles_pkg::hles_addr_type ADDR,
  input wire hles_pkg::hles_byte_type WDATA,
  input wire logic                    WR,
  input wire logic                    RD,
  input wire hles_pkg::hles_byte_type RDATA,
  // Controller events, receive bit valid and interrupt request
  input wire logic                    TX_START,
  input wire logic                    TX_END,
  input wire logic                    RX_START,
  input wire logic                    RX_END,
  input wire logic                    RX_BUFFER_FULL,
  input wire logic                    RX_FRAME_CHECK_ERROR_EVENT,
  input wire logic                    RX_MESSAGE_KIND,
  input wire logic                    RX_BIT_VALID,
  input wire logic                    IRQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  logic any_ev;
  assign any_ev = TX_START | TX_END | RX_START | RX_END | RX_BUFFER_FULL
                | RX_FRAME_CHECK_ERROR_EVENT | RX_BIT_VALID;

  sequence rd_s;
    RD && ADDR == STATUS_INDEX;
  endsequence
  sequence quiet_rd_s;
    rd_s ##0 !any_ev;
  endsequence

  tx_start_a: assert property (TX_START ##1 rd_s |=> RDATA[6])
    else $error("transmit start missing");
  rx_start_a: assert property (RX_START ##1 rd_s |=> RDATA[5])
    else $error("receive start missing");
  tx_end_a: assert property (TX_END ##1 rd_s |=> RDATA[4])
    else $error("transmit end missing");
  fcs_err_a: assert property (RX_FRAME_CHECK_ERROR_EVENT ##1 rd_s |=> RDATA[2])
    else $error("frame check error missing");
  rx_end_kind_a: assert property (
    RX_START ##1 (RX_END || RX_BUFFER_FULL) ##1 rd_s
    |=> RDATA[3] && RDATA[7] == $past(RX_MESSAGE_KIND, 2))
    else $error("receive end or kind wrong");
  read_clears_a: assert property (
    quiet_rd_s ##1 rd_s |=> RDATA[6:0] == 7'h00)
    else $error("events not cleared by read");
  race_keep_a: assert property (
    rd_s ##0 TX_START ##1 rd_s |=> RDATA[6])
    else $error("event lost in clearing read");
  irq_mask_a: assert property (
    (WR && ADDR == ENABLE_INDEX && WDATA == 8'h00) ##1 !WR |=> !IRQ)
    else $error("request while all disabled");
endmodule

bind hles_status hles_status_properties u_props (
  .CLK, .RESET_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .TX_START, .TX_END,
  .RX_START, .RX_END, .RX_BUFFER_FULL, .RX_FRAME_CHECK_ERROR_EVENT, .RX_MESSAGE_KIND,
  .RX_BIT_VALID, .IRQ);

// ---- testbench/hles_link_source.sv ----
// Line-side model that sends octets onto the receive data link
module hles_link_source (
  // Clock
  input  wire logic       clk,
  // Octet request
  input  wire logic       send,
  input  wire logic [7:0] octet,
  output logic            busy,
  // Receive line
  output logic            bit_out,
  output logic            bit_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] shift;
  logic [3:0] left;

  initial begin
    shift = 8'h00;
    left = 4'h0;
    bit_out = 1'b0;
    bit_valid = 1'b0;
  end

  assign busy = send || (left != 4'h0);

  // Least significant bit first; between octets the line toggles so a
  // stale bit never passes for data
  always @(posedge clk) begin
    bit_valid <= (left != 4'h0);
    if (left != 4'h0) begin
      bit_out <= shift[0];
      shift <= shift >> 1;
      left <= left - 4'h1;
    end else begin
      bit_out <= ~bit_out;
      if (send) begin
        shift <= octet;
        left <= 4'h8;
      end
    end
  end
endmodule

// ---- testbench/hles_status_tb_top.sv ----
// Self-checking bench for the data link event status bank
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module hles_status_tb_top
  import hles_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic          clk, reset_n, wr, rd, kind, send, irq, irq_seen;
  logic          rx_bit, rx_bit_valid, busy;
  logic [5:0]    ev;
  hles_addr_type addr;
  hles_byte_type wdata, rdata, octet, d1, d2, k;
  int            miscompares, samples_checked;

  hles_status DUT (
    .CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .TX_START(ev[0]), .RX_START(ev[1]),
    .TX_END(ev[2]), .RX_END(ev[3]), .RX_FRAME_CHECK_ERROR_EVENT(ev[4]),
    .RX_BUFFER_FULL(ev[5]), .RX_MESSAGE_KIND(kind), .RX_BIT(rx_bit),
    .RX_BIT_VALID(rx_bit_valid), .IRQ(irq));

  hles_link_source u_link (
    .clk(clk), .send(send), .octet(octet), .busy(busy),
    .bit_out(rx_bit), .bit_valid(rx_bit_valid));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic complete_run();
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr_reg(input hles_addr_type a, input hles_byte_type d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Two back-to-back reads: the second shows what is left after the first cleared
  task automatic rd2(input hles_addr_type a, output hles_byte_type r1,
                     output hles_byte_type r2);
    @(posedge clk);
    ev <= 6'h00;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    #1 r1 = rdata;
    irq_seen = irq;
    @(posedge clk);
    rd <= 1'b0;
    #1 r2 = rdata;
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
  endtask

  task automatic send_octet(input hles_byte_type o);
    int n;
    @(posedge clk);
    send <= 1'b1;
    ev <= 6'h00;
    octet <= o;
    @(posedge clk);
    send <= 1'b0;
    #1;
    for (n = 0; n < 20 && busy; n++) begin
      @(posedge clk);
      #1;
    end
    if (busy) begin
      miscompares++;
      complete_run();
    end
  endtask

  initial begin
    reset_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    send = 1'b0;
    kind = 1'b0;
    ev = 6'h00;
    addr = 4'h0;
    wdata = 8'h00;
    octet = 8'h00;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rd2(STATUS_INDEX, d1, d2);
    `CHK(d1, 8'h00)
    rd2(4'h5, d1, d2);
    `CHK(d1, 8'h00)
    wr_reg(STATUS_INDEX, 8'hFF);
    rd2(STATUS_INDEX, d1, d2);
    `CHK(d1, 8'h00)
    wr_reg(ENABLE_INDEX, 8'hFF);
    rd2(ENABLE_INDEX, d1, d2);
    `CHK(d1, 8'h7F)
    @(posedge clk);
    kind <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      rd2(STATUS_INDEX, d1, d2);
      k = (i >= 3) ? 8'h80 : 8'h00;
      `CHK(d1, (8'h40 >> i) | k)
      `CHK(d2, k)
      `CHK(irq_seen, 1'b1)
    end
    // A second end of the same message must be ignored
    pulse(5);
    rd2(STATUS_INDEX, d1, d2);
    `CHK(d1, 8'h80)
    @(posedge clk);
    kind <= 1'b0;
    pulse(1);
    @(posedge clk);
    ev <= 6'h20;
    rd2(STATUS_INDEX, d1, d2);
    `CHK(d1, 8'h28)
    @(posedge clk);
    ev <= 6'h01;
    addr <= STATUS_INDEX;
    rd <= 1'b1;
    rd2(STATUS_INDEX, d1, d2);
    `CHK(d1, 8'h40)
    `CHK(d2, 8'h00)
    send_octet(8'h7E);
    rd2(STATUS_INDEX, d1, d2);
    `CHK(d1, 8'h01)
    send_octet(8'hFF);
    rd2(STATUS_INDEX, d1, d2);
    `CHK(d1, 8'h02)
    // Start, end and flag together mark a whole received message
    pulse(1);
    @(posedge clk);
    ev <= 6'h08;
    send_octet(8'h7E);
    rd2(STATUS_INDEX, d1, d2);
    `CHK(d1, 8'h29)
    // All enables off: transmit start and end still latch but raise no request
    wr_reg(ENABLE_INDEX, 8'h00);
    pulse(0);
    rd2(STATUS_INDEX, d1, d2);
    `CHK(d1, 8'h40)
    `CHK(irq_seen, 1'b0)
    pulse(2);
    rd2(STATUS_INDEX, d1, d2);
    `CHK(d1, 8'h10)
    `CHK(irq_seen, 1'b0)
    complete_run();
  end
endmodule
